// ---- agc_lock_pkg.sv ----
// shared constants for the gain-threshold and lock-detect register bank
package agc_lock_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int STRENGTH_W = 8;
    localparam int GAIN_W = 5;
    localparam int CNT_W = 10;
    localparam int PHASE_W = 4;
    localparam int NUM_EXT_SRC = 9;
    localparam int IRQ_W = 3;
    // register offsets
    localparam logic [7:0] OFS_GAIN_DROP = 8'h13;
    localparam logic [7:0] OFS_GAIN_RAISE = 8'h14;
    localparam logic [7:0] OFS_LOCK_CTRL = 8'h15;
    localparam logic [7:0] OFS_AGC_CTRL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h19;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1A;
    localparam logic [7:0] OFS_STATE = 8'h1B;
    // reset values
    localparam logic [7:0] RST_GAIN_DROP = 8'h38;
    localparam logic [7:0] RST_GAIN_RAISE = 8'h38;
    localparam logic [7:0] RST_LOCK_CTRL = 8'h00;
    localparam logic [7:0] RST_AGC_CTRL = 8'h02;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    // field positions
    localparam int FLD_HI_LSB = 5;
    localparam int LOCK_SEL_LSB = 4;
    localparam int WIN_BIT = 3;
    localparam int MODE_BIT = 2;
    localparam int AGC_OFF_BIT = 0;
    localparam int FILT_BIT = 1;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_GAIN_STEP = 2;
    // strength level arithmetic, one step is 1.5 dB
    localparam int STEP_CENTI_DB = 150;
    localparam logic [7:0] AGC_BASE_OFFSET = 8'h08;
    localparam logic [7:0] DROP_BASE = 8'h03;
    // lock detector
    localparam logic [PHASE_W-1:0] WIN_NARROW = 4'h2;
    localparam logic [PHASE_W-1:0] WIN_WIDE = 4'h4;
    localparam logic [CNT_W-1:0] LOCK_TH_0 = 10'h07F;
    localparam logic [CNT_W-1:0] LOCK_TH_1 = 10'h0FF;
    localparam logic [CNT_W-1:0] LOCK_TH_2 = 10'h1FF;
    localparam logic [CNT_W-1:0] LOCK_TH_3 = 10'h3FF;
    localparam logic [CNT_W-1:0] UNLOCK_GAP = 10'h010;
    // lock pin selector codes
    localparam logic [3:0] SEL_ZERO = 4'h0;
    localparam logic [3:0] SEL_ONE = 4'h1;
    localparam logic [3:0] SEL_SUSTAINED = 4'h2;
    localparam logic [3:0] SEL_MOMENTARY = 4'h3;
    localparam logic [3:0] SEL_CARRIER = 4'h4;
    localparam logic [3:0] SEL_CAL = 4'h5;
    localparam logic [3:0] SEL_FAULT = 4'h6;
    localparam logic [3:0] SEL_FIRST_CLK = 4'h7;
endpackage : agc_lock_pkg

// ---- bit_sync.sv ----
// two-flop synchroniser for a group of unrelated level inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // each bit synchronised on its own, no coherence between bits
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta <= async_in[i];
                sync_out[i] <= meta;
            end
        end
    end
endmodule : bit_sync

// ---- lock_counter.sv ----
// pll lock detector: window test, lock counter and lock hysteresis
`timescale 1ns/1ps
module lock_counter
    import agc_lock_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [agc_lock_pkg::PHASE_W-1:0] phase_err,
    input wire logic wide,
    input wire logic updown,
    input wire logic [1:0] accuracy,
    output logic sustained,
    output logic momentary
);
    import agc_lock_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] lock_th;
    logic [CNT_W-1:0] unlock_th;
    logic in_win;

    // window is 2 or 4 prescaler cycles wide
    assign in_win = phase_err < (wide ? WIN_WIDE : WIN_NARROW);

    // thresholds per accuracy code, loss sits 16 below lock
    always_comb begin
        unique case (accuracy)
            2'h0: lock_th = LOCK_TH_0;
            2'h1: lock_th = LOCK_TH_1;
            2'h2: lock_th = LOCK_TH_2;
            2'h3: lock_th = LOCK_TH_3;
        endcase
        unlock_th = lock_th - UNLOCK_GAP;
    end

    // counter saturates both ways so a long lock never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            momentary <= 1'b0;
        end else if (tick) begin
            momentary <= in_win;
            if (in_win && count != LOCK_TH_3) begin
                count <= count + 10'h001;
            end else if (!in_win && !updown) begin
                count <= '0;
            end else if (!in_win && count != '0) begin
                count <= count - 10'h001;
            end
        end
    end

    // declared at the lock value, lost at the lower value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sustained <= 1'b0;
        end else if (count >= lock_th) begin
            sustained <= 1'b1;
        end else if (count <= unlock_th) begin
            sustained <= 1'b0;
        end
    end

    sequence s_miss_restart;
        tick && !updown && !in_win;
    endsequence

    AST_RESTART_CLEAR: assert property (@(posedge clk) disable iff (rst)
        s_miss_restart |=> count == '0)
        else $error("restart mode did not clear the counter");
    AST_UPDOWN_DEC: assert property (@(posedge clk) disable iff (rst)
        tick && updown && !in_win && count > '0 |=> count == $past(count) - 1)
        else $error("up/down mode did not decrement");
    AST_NARROW_WIN: assert property (@(posedge clk) disable iff (rst)
        tick && !wide && phase_err == 4'h2 |=> !momentary)
        else $error("narrow window accepted an error of two");
    AST_LOCK_DECLARE: assert property (@(posedge clk) disable iff (rst)
        accuracy == 2'h0 && count == 10'h07F |=> sustained)
        else $error("lock not declared at 127");
endmodule : lock_counter

// ---- agc_lock_cfg.sv ----
// gain thresholds, carrier reference and lock detector register bank
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module agc_lock_cfg
    import agc_lock_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [agc_lock_pkg::ADDR_W-1:0] ADDR,
    input wire logic [agc_lock_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [agc_lock_pkg::DATA_W-1:0] RDATA,
    input wire logic RX_ON,
    input wire logic [agc_lock_pkg::STRENGTH_W-1:0] STRENGTH,
    input wire logic STRENGTH_VALID,
    input wire logic REF_TICK,
    input wire logic [agc_lock_pkg::PHASE_W-1:0] PHASE_ERR,
    input wire logic CAL_DONE_IN,
    input wire logic SEQ_FAULT_IN,
    input wire logic [agc_lock_pkg::NUM_EXT_SRC-1:0] EXT_SRC,
    output logic [agc_lock_pkg::GAIN_W-1:0] GAIN,
    output logic LOCK_PIN,
    output logic IRQ
);
    import agc_lock_pkg::*;

    logic [DATA_W-1:0] gain_drop_and_initial_gain;
    logic [DATA_W-1:0] gain_raise_and_sense_reference;
    logic [DATA_W-1:0] lock_detector_control;
    logic [DATA_W-1:0] agc_control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [GAIN_W-1:0] init_gain;
    logic [GAIN_W-1:0] sense_ref;
    logic [2:0] drop_field;
    logic [2:0] raise_field;
    logic [3:0] pin_sel;
    logic auto_gain_off;
    logic auto_gain_two_sample_filter;
    logic [STRENGTH_W-1:0] raise_th;
    logic [STRENGTH_W-1:0] drop_th;
    logic rx_prev;
    logic agc_run;
    logic want_up;
    logic want_dn;
    logic pend_up;
    logic pend_dn;
    logic do_up;
    logic do_dn;
    logic carrier;
    logic sustained_pll_locked;
    logic momentary_pll_locked;
    logic lock_prev;
    logic cal_done;
    logic sequencing_fault;
    logic [NUM_EXT_SRC-1:0] ext_src_sync;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic next_lock_pin;

    // field views
    assign drop_field = gain_drop_and_initial_gain[7:FLD_HI_LSB];
    assign init_gain = gain_drop_and_initial_gain[GAIN_W-1:0];
    assign raise_field = gain_raise_and_sense_reference[7:FLD_HI_LSB];
    assign sense_ref = gain_raise_and_sense_reference[GAIN_W-1:0];
    assign pin_sel = lock_detector_control[7:LOCK_SEL_LSB];
    assign auto_gain_off = agc_control[AGC_OFF_BIT];
    assign auto_gain_two_sample_filter = agc_control[FILT_BIT];

    // software writes; unmapped writes are dropped
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            gain_drop_and_initial_gain <= RST_GAIN_DROP;
            gain_raise_and_sense_reference <= RST_GAIN_RAISE;
            lock_detector_control <= RST_LOCK_CTRL;
            agc_control <= RST_AGC_CTRL;
            irq_mask <= RST_IRQ_MASK[IRQ_W-1:0];
        end else if (WR) begin
            unique case (ADDR)
                OFS_GAIN_DROP: gain_drop_and_initial_gain <= WDATA;
                OFS_GAIN_RAISE: gain_raise_and_sense_reference <= WDATA;
                OFS_LOCK_CTRL: lock_detector_control <= WDATA;
                OFS_AGC_CTRL: agc_control <= {6'h00, WDATA[1:0]};
                OFS_IRQ_MASK: irq_mask <= WDATA[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                OFS_GAIN_DROP: RDATA <= gain_drop_and_initial_gain;
                OFS_GAIN_RAISE: RDATA <= gain_raise_and_sense_reference;
                OFS_LOCK_CTRL: RDATA <= lock_detector_control;
                OFS_AGC_CTRL: RDATA <= agc_control;
                OFS_IRQ_STATUS: RDATA <= {5'h00, irq_status};
                OFS_IRQ_MASK: RDATA <= {5'h00, irq_mask};
                OFS_STATE: RDATA <= {sustained_pll_locked,
                    momentary_pll_locked, carrier, GAIN};
                default: RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // thresholds in strength steps of 1.5 dB, no dB conversion done here
    always_comb begin
        raise_th = {3'h0, sense_ref} + AGC_BASE_OFFSET
            + {5'h00, raise_field};
        drop_th = raise_th + DROP_BASE + {5'h00, drop_field};
    end

    // decisions on the sampled level
    assign agc_run = RX_ON && rx_prev && !auto_gain_off;
    assign want_up = STRENGTH < raise_th && GAIN < init_gain;
    assign want_dn = STRENGTH > drop_th && GAIN != '0;
    // filter delays a step until the second agreeing sample
    assign do_up = agc_run && STRENGTH_VALID && GAIN <= init_gain && want_up
        && (!auto_gain_two_sample_filter || pend_up);
    assign do_dn = agc_run && STRENGTH_VALID && GAIN <= init_gain && want_dn
        && (!auto_gain_two_sample_filter || pend_dn);

    // receive chain edge detect, restarts gain at power-on
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rx_prev <= 1'b0;
        end else begin
            rx_prev <= RX_ON;
        end
    end

    // gain loop; a lowered cap pulls the gain down at once
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            GAIN <= RST_GAIN_DROP[GAIN_W-1:0];
            pend_up <= 1'b0;
            pend_dn <= 1'b0;
        end else if (!agc_run) begin
            GAIN <= init_gain;
            pend_up <= 1'b0;
            pend_dn <= 1'b0;
        end else if (GAIN > init_gain) begin
            GAIN <= init_gain;
            pend_up <= 1'b0;
            pend_dn <= 1'b0;
        end else if (STRENGTH_VALID) begin
            if (do_up) begin
                GAIN <= GAIN + 5'h01;
            end else if (do_dn) begin
                GAIN <= GAIN - 5'h01;
            end
            pend_up <= want_up && auto_gain_two_sample_filter
                && !pend_up;
            pend_dn <= want_dn && auto_gain_two_sample_filter
                && !pend_dn;
        end
    end

    // carrier sense against the same reference as the gain loop
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            carrier <= 1'b0;
        end else if (!RX_ON) begin
            carrier <= 1'b0;
        end else if (STRENGTH_VALID) begin
            carrier <= STRENGTH > {3'h0, sense_ref};
        end
    end

    lock_counter u_lock (
        .clk(REF_CLK),
        .rst(RST),
        .tick(REF_TICK),
        .phase_err(PHASE_ERR),
        .wide(lock_detector_control[WIN_BIT]),
        .updown(lock_detector_control[MODE_BIT]),
        .accuracy(lock_detector_control[1:0]),
        .sustained(sustained_pll_locked),
        .momentary(momentary_pll_locked)
    );

    // pin sources from other domains; clocks arrive as sampled levels,
    // so only clocks well below half the reference rate look right
    bit_sync #(
        .WIDTH(NUM_EXT_SRC + 2)
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .async_in({EXT_SRC, SEQ_FAULT_IN, CAL_DONE_IN}),
        .sync_out({ext_src_sync, sequencing_fault, cal_done})
    );

    // lock pin source selection, status sources inverted
    always_comb begin
        unique case (pin_sel)
            SEL_ZERO: next_lock_pin = 1'b0;
            SEL_ONE: next_lock_pin = 1'b1;
            SEL_SUSTAINED: next_lock_pin = !sustained_pll_locked;
            SEL_MOMENTARY: next_lock_pin = !momentary_pll_locked;
            SEL_CARRIER: next_lock_pin = !carrier;
            SEL_CAL: next_lock_pin = !cal_done;
            SEL_FAULT: next_lock_pin = !sequencing_fault;
            default: next_lock_pin = ext_src_sync[pin_sel - SEL_FIRST_CLK];
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            LOCK_PIN <= 1'b0;
        end else begin
            LOCK_PIN <= next_lock_pin;
        end
    end

    // events: lock gained, lock lost, gain stepped
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= sustained_pll_locked;
        end
    end

    assign irq_event = {do_up || do_dn,
        lock_prev && !sustained_pll_locked,
        !lock_prev && sustained_pll_locked};
    assign irq_clear = (WR && ADDR == OFS_IRQ_STATUS) ? WDATA[IRQ_W-1:0] : '0;

    // a new event beats a clear in the same cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    assign IRQ = |(irq_status & irq_mask);

    sequence s_run_sample;
        agc_run && STRENGTH_VALID && GAIN <= init_gain;
    endsequence

    AST_GAIN_CEIL: assert property (@(posedge REF_CLK) disable iff (RST)
        GAIN <= $past(init_gain))
        else $error("gain above the initial gain cap");
    AST_GAIN_OFF_HOLD: assert property (@(posedge REF_CLK)
        disable iff (RST)
        auto_gain_off ##1 auto_gain_off |-> GAIN == $past(init_gain))
        else $error("gain moved while the gain loop was off");
    AST_RAISE: assert property (@(posedge REF_CLK) disable iff (RST)
        s_run_sample ##0 !auto_gain_two_sample_filter && want_up
        |=> GAIN == $past(GAIN) + 5'h01)
        else $error("gain not raised below the raise threshold");
    AST_DROP: assert property (@(posedge REF_CLK) disable iff (RST)
        s_run_sample ##0 !auto_gain_two_sample_filter
        && STRENGTH == drop_th + 8'h01 && GAIN != '0
        |=> GAIN == $past(GAIN) - 5'h01)
        else $error("gain not dropped above the drop threshold");
    AST_DROP_EDGE: assert property (@(posedge REF_CLK) disable iff (RST)
        s_run_sample ##0 STRENGTH == drop_th |=> GAIN >= $past(GAIN))
        else $error("gain dropped at the threshold itself");
    AST_FILTER_FIRST: assert property (@(posedge REF_CLK)
        disable iff (RST)
        s_run_sample ##0 auto_gain_two_sample_filter && want_up && !pend_up
        |=> GAIN == $past(GAIN))
        else $error("filtered loop stepped on a single sample");
    AST_PIN_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
        pin_sel == SEL_ZERO ##1 pin_sel == SEL_ZERO |-> !LOCK_PIN)
        else $error("lock pin not low for code zero");
    AST_PIN_LOCK: assert property (@(posedge REF_CLK) disable iff (RST)
        pin_sel == SEL_SUSTAINED |=> LOCK_PIN == !$past(sustained_pll_locked))
        else $error("lock pin not inverted sustained lock");
    AST_IRQ_LEVEL: assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(sustained_pll_locked) && irq_mask[IRQ_LOCK_GAIN]
        |=> IRQ [*2])
        else $error("lock gain event not raised on the interrupt");
endmodule : agc_lock_cfg

// ---- cfg_host.sv ----
// host microcontroller model driving the register port of the bank
`timescale 1ns/1ps
module cfg_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    import agc_lock_pkg::*;

    // idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one-cycle write; released lines are scrambled so stale values
    // can never pass for a held request
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : write_reg

    // read strobe for one cycle; data stands only in the cycle after it
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : read_reg

    // the host picks the sustained-lock source to use the pin as lock flag
    task automatic use_lock_pin(input logic [3:0] low_bits);
        write_reg(OFS_LOCK_CTRL, {SEL_SUSTAINED, low_bits});
    endtask : use_lock_pin
endmodule : cfg_host

// ---- tb_top.sv ----
// self-checking bench for the gain threshold and lock detect bank
`timescale 1ns/1ps
module tb_top;
    import agc_lock_pkg::*;
    logic ref_clk, rst, wr, rd, rx_on, valid, ref_tick, cal_done, seq_fault;
    logic [7:0] addr, wdata, rdata, strength, d, drop_r, raise_r, agc_r;
    logic [3:0] phase_err;
    logic [8:0] ext_src;
    logic [4:0] gain;
    logic lock_pin, irq;
    logic [31:0] seed = 32'hA449B749;
    logic [31:0] r;
    int miscompares = 0;
    int n_tests = 0;
    int g, armed; // armed: 0 none, 1 up, -1 down

    cfg_host host (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    agc_lock_cfg dut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_ON(rx_on),
        .STRENGTH(strength), .STRENGTH_VALID(valid), .REF_TICK(ref_tick),
        .PHASE_ERR(phase_err), .CAL_DONE_IN(cal_done),
        .SEQ_FAULT_IN(seq_fault), .EXT_SRC(ext_src), .GAIN(gain),
        .LOCK_PIN(lock_pin), .IRQ(irq));

    // 50 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // xorshift generator, fixed seed keeps runs repeatable
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // gain thresholds in 1.5 dB strength steps
    function automatic int up_level();
        return raise_r[4:0] + 8 + raise_r[7:5];
    endfunction : up_level

    function automatic int dn_level();
        return up_level() + 3 + drop_r[7:5];
    endfunction : dn_level

    // expected gain loop reaction to one strength sample
    function automatic void expect_gain(input int s);
        int dir;
        dir = (s < up_level() && g < drop_r[4:0]) ? 1 :
            ((s > dn_level() && g > 0) ? -1 : 0);
        if (agc_r[0] || dir == 0) begin
            armed = 0;
        end else if (!agc_r[1] || armed == dir) begin
            g = g + dir;
            armed = 0;
        end else begin
            armed = dir;
        end
    endfunction : expect_gain

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, d);
        chk(d, exp);
    endtask : rd_chk

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cycles

    // one strength sample, then the gain is compared with the model
    task automatic sample(input int s);
        @(posedge ref_clk);
        strength <= s[7:0];
        valid <= 1'b1;
        @(posedge ref_clk);
        valid <= 1'b0;
        #1;
        expect_gain(s);
        chk({3'h0, gain}, g[7:0]);
    endtask : sample

    // reprogram the loop with the receiver off, then restart it
    task automatic gain_setup(input logic [7:0] dr, ur, ar);
        drop_r = dr;
        raise_r = ur;
        agc_r = ar;
        @(posedge ref_clk);
        rx_on <= 1'b0;
        host.write_reg(OFS_GAIN_DROP, dr);
        host.write_reg(OFS_GAIN_RAISE, ur);
        host.write_reg(OFS_AGC_CTRL, ar);
        cycles(2);
        chk({3'h0, gain}, {3'h0, dr[4:0]});
        @(posedge ref_clk);
        rx_on <= 1'b1;
        cycles(3);
        g = dr[4:0];
        armed = 0;
        sample(up_level());
    endtask : gain_setup

    // one reference tick; phase error is scrambled once released
    task automatic tick(input logic [3:0] pe);
        @(posedge ref_clk);
        ref_tick <= 1'b1;
        phase_err <= pe;
        @(posedge ref_clk);
        ref_tick <= 1'b0;
        phase_err <= ~pe;
    endtask : tick

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // watchdog well beyond the expected five thousand cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        {rst, rx_on, valid, ref_tick, cal_done, seq_fault} = 6'h20;
        {strength, phase_err, ext_src} = 21'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, unmapped read and the read-only bits of loop control
        chk({3'h0, gain}, 8'h18);
        rd_chk(OFS_GAIN_DROP, 8'h38);
        rd_chk(OFS_GAIN_RAISE, 8'h38);
        rd_chk(OFS_LOCK_CTRL, 8'h00);
        rd_chk(OFS_AGC_CTRL, 8'h02);
        rd_chk(OFS_IRQ_MASK, 8'h00);
        rd_chk(8'h20, 8'h00);
        host.write_reg(OFS_AGC_CTRL, 8'hFF);
        rd_chk(OFS_AGC_CTRL, 8'h03);
        r = next_rand();
        host.write_reg(OFS_LOCK_CTRL, r[7:0]);
        rd_chk(OFS_LOCK_CTRL, r[7:0]);
        // gain loop: two hand-picked corners, then random settings
        for (int k = 0; k < 8; k++) begin
            r = next_rand();
            gain_setup(k == 0 ? 8'hE0 : (k == 1 ? 8'h1F : r[7:0]), r[15:8],
                k < 2 ? {7'h0, k[0]} << 1 : {6'h0, r[18], r[17:16] == 2'h0});
            for (int j = 0; j < 12; j++) begin
                r = next_rand();
                sample(r[3:2] == 2'h0 ? up_level() : (r[4] ?
                    up_level() - 1 - r[1:0] : dn_level() + 1 + r[1:0]));
            end
        end
        // every selector code apart from the lock sources, both levels
        for (int c = 0; c < 16; c++) begin
            if (c == 2 || c == 3) continue;
            host.write_reg(OFS_LOCK_CTRL, {c[3:0], 4'h0});
            for (int v = 0; v < 2; v++) begin
                @(posedge ref_clk);
                cal_done <= v[0];
                seq_fault <= v[0];
                if (c >= 7) ext_src <= v[0] ? 9'h001 << (c - 7) :
                    ~(9'h001 << (c - 7));
                if (c == 4) sample(v[0] ? 255 : 0);
                cycles(5);
                chk({7'h0, lock_pin},
                    {7'h0, c < 2 ? c[0] : (c < 7) ^ v[0]});
            end
        end
        // window edges with the momentary lock source on the pin
        for (int w = 0; w < 4; w++) begin
            host.write_reg(OFS_LOCK_CTRL, {SEL_MOMENTARY, w[1], 3'h0});
            tick(w[1] ? 4'h3 + w[0] : 4'h1 + w[0]);
            cycles(3);
            chk({7'h0, lock_pin}, {7'h0, w[0]});
        end
        // lock thresholds for each accuracy code, restart mode
        for (int a = 0; a < 4; a++) begin
            host.use_lock_pin({2'h0, a[1:0]});
            tick(4'h9);
            repeat ((128 << a) - 2) tick(4'h0);
            cycles(4);
            chk({7'h0, lock_pin}, 8'h01);
            tick(4'h0);
            cycles(4);
            chk({7'h0, lock_pin}, 8'h00);
        end
        // one miss restarts the count, up/down mode only steps down
        host.use_lock_pin(4'h0);
        tick(4'hA);
        cycles(4);
        chk({7'h0, lock_pin}, 8'h01);
        repeat (127) tick(4'h1);
        host.use_lock_pin(4'h4);
        repeat (15) tick(4'hF);
        cycles(4);
        chk({7'h0, lock_pin}, 8'h00);
        tick(4'hF);
        cycles(4);
        chk({7'h0, lock_pin}, 8'h01);
        // interrupt raised, masked and cleared
        chk({7'h0, irq}, 8'h00);
        host.write_reg(OFS_IRQ_MASK, 8'h02);
        cycles(1);
        chk({7'h0, irq}, 8'h01);
        rd_chk(OFS_IRQ_STATUS, 8'h07);
        host.write_reg(OFS_IRQ_MASK, 8'h00);
        cycles(1);
        chk({7'h0, irq}, 8'h00);
        host.write_reg(OFS_IRQ_MASK, 8'h02);
        host.write_reg(OFS_IRQ_STATUS, 8'h07);
        cycles(1);
        chk({7'h0, irq}, 8'h00);
        rd_chk(OFS_IRQ_STATUS, 8'h00);
        // state view: unlocked, last miss, strong carrier, model gain
        rd_chk(OFS_STATE, {3'h1, g[4:0]});
        cycles(1);
        chk(rdata, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
